// ===== ctm_cfg.svh
// Purpose: Constants of the core timer: register indices, field positions, reset values, counts
// Assumes: Included by its bare name from the timer module and the testbench
// Notes:   Byte address of a register is four times its index
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define CTM_IDX_CTRL     10'h008
`define CTM_IDX_COUNT    10'h009

// ----------------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------------
`define CTM_BIT_OVF      7
`define CTM_BIT_PER      6
`define CTM_BIT_OVF_EN   5
`define CTM_BIT_PER_EN   4
`define CTM_BIT_OVF_CLR  3
`define CTM_BIT_PER_CLR  2
`define CTM_BIT_RATE_HI  1
`define CTM_BIT_RATE_LO  0
`define CTM_RATE_RST     2'h3

// ----------------------------------------------------------------------------
// Divider chain and timing
// ----------------------------------------------------------------------------
`define CTM_PRE_BITS     2
`define CTM_CNT_BITS     8
`define CTM_TAP0_BITS    12
`define CTM_TAPS         4
`define CTM_CHAIN_BITS   15
`define CTM_COP_BITS     3
// Oscillator stabilisation, 4064 cycles
`define CTM_STAB_CYC     13'h0fe0

`endif

// ===== ctm_core_timer.sv
// Purpose: Core timer with overflow flag, periodic interrupt, watchdog and power modes
// Assumes: pclk is the bus clock E; CPU requests stop and wait with one-cycle pulses
// Notes:   APB slave answers with no wait state; pins pass two flip-flops first
`include "ctm_cfg.svh"
`default_nettype none

// Contract
// - Divide by four, then 8-bit counter chain
// - Counter value readable at register index 09
// - Overflow flag on wrap, direct writes ignored
// - Overflow rate is clock divided by 1024
// - Two stages then periodic circuit, four taps
// - Watchdog divides periodic output by eight
// - Writing one to overflow clear clears flag
// - Periodic flag set on tap, cleared by one
// - Overflow flag with enable requests interrupt
// - Periodic flag with enable requests interrupt
// - Both flag clear bits always read zero
// - Rate select picks 2^12 to 2^15 period
// - Reset sets both rate select bits
// - Watchdog timeout seven to eight periods
// - Stop clears and halts the counter chain
// - Stop clears CPU mask, pending external interrupt exits
// - Stop ends on external interrupt, low-power or reset
// - Wait keeps timer, any interrupt ends it
// - Low-power reset holds, then 4064 stabilisation cycles
// - Stop leaves the external interrupt mask alone
// - Watchdog clear resets only final stage
// - Other resets clear chain without stabilisation
module ctm_core_timer #(
    parameter logic [12:0] STAB_CYCLES = `CTM_STAB_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // CPU side
    input  wire logic        stop_req,
    input  wire logic        wait_req,
    input  wire logic        wdog_clear,
    output logic             timer_irq,
    output logic             cpu_reset,
    output logic             cpu_halt,
    output logic             cpu_irq_mask_clear,
    output logic             osc_run,
    // Pins
    input  wire logic        ext_irq_pin,
    input  wire logic        low_power_reset_pin_n,
    input  wire logic        ext_reset_pin_n
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    wire  [2:0] pins = {ext_irq_pin, ext_reset_pin_n, low_power_reset_pin_n};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 3'h3;
            sync2_q <= 3'h3;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    wire lp_rst  = ~sync2_q[0];
    wire ext_rst = ~sync2_q[1];
    wire ext_irq = sync2_q[2];

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    ctm_pkg::ctm_mode_e mode_q;
    ctm_pkg::ctm_mode_e mode_d;
    logic [`CTM_CHAIN_BITS-1:0] chain_q;
    logic [`CTM_COP_BITS-1:0]   cop_q;
    logic [12:0]                stab_cnt_q;
    logic                       wdog_bite_q;
    logic                       ovf_flag_q;
    logic                       per_flag_q;
    logic                       ovf_en_q;
    logic                       per_en_q;
    ctm_pkg::ctm_rate_t         rate_q;
    logic                       pready_q;
    logic                       pslverr_q;
    logic [31:0]                prdata_q;
    logic                       irq_q;
    logic                       cpu_reset_q;
    logic                       cpu_halt_q;
    logic                       mask_clr_q;
    logic                       osc_run_q;

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    wire in_stop   = (mode_q == ctm_pkg::MODE_STOP);
    wire in_wait   = (mode_q == ctm_pkg::MODE_WAIT);
    wire in_low_power_reset_pin  = (mode_q == ctm_pkg::MODE_LOW_POWER_RESET_PIN);
    wire in_stab   = (mode_q == ctm_pkg::MODE_STAB);
    wire stab_done = in_stab & (stab_cnt_q == STAB_CYCLES - 13'h001);
    // Reset of flags, enables and rate select, not of the counter chain
    wire soft_rst  = ext_rst | in_low_power_reset_pin | in_stab | wdog_bite_q;
    wire irq_raw   = (ovf_flag_q & ovf_en_q) | (per_flag_q & per_en_q);

    // ------------------------------------------------------------------------
    // Divider chain
    // ------------------------------------------------------------------------
    wire chain_clr = in_stop | in_low_power_reset_pin | stab_done | ext_rst | wdog_bite_q;
    wire chain_adv = ~chain_clr;
    wire [`CTM_CNT_BITS-1:0] count_val =
        chain_q[`CTM_PRE_BITS+`CTM_CNT_BITS-1:`CTM_PRE_BITS];
    wire ovf_tick  = chain_adv & (&chain_q[`CTM_PRE_BITS+`CTM_CNT_BITS-1:0]);

    logic [`CTM_TAPS-1:0] tap_ones;
    genvar gi;
    generate
        for (gi = 0; gi < `CTM_TAPS; gi = gi + 1) begin : g_tap
            assign tap_ones[gi] = &chain_q[`CTM_TAP0_BITS-1+gi:0];
        end
    endgenerate

    wire per_tick = chain_adv & tap_ones[rate_q];
    wire cop_bite = per_tick & (&cop_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_q <= '0;
        end else if (chain_clr) begin
            chain_q <= '0;
        end else begin
            chain_q <= chain_q + 15'h0001;
        end
    end

    // Watchdog stage: only this stage is cleared by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cop_q       <= '0;
            wdog_bite_q <= 1'b0;
        end else begin
            wdog_bite_q <= cop_bite;
            if (chain_clr | wdog_clear) begin
                cop_q <= '0;
            end else if (per_tick) begin
                cop_q <= cop_q + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Power mode sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            ctm_pkg::MODE_RUN: begin
                if (stop_req) begin
                    mode_d = ctm_pkg::MODE_STOP;
                end else if (wait_req) begin
                    mode_d = ctm_pkg::MODE_WAIT;
                end
            end
            ctm_pkg::MODE_WAIT: begin
                if (ext_irq | irq_raw) begin
                    mode_d = ctm_pkg::MODE_RUN;
                end
            end
            ctm_pkg::MODE_STOP: begin
                if (ext_irq) begin
                    mode_d = ctm_pkg::MODE_RUN;
                end
            end
            ctm_pkg::MODE_LOW_POWER_RESET_PIN: begin
                mode_d = ctm_pkg::MODE_STAB;
            end
            ctm_pkg::MODE_STAB: begin
                if (stab_done) begin
                    mode_d = ctm_pkg::MODE_RUN;
                end
            end
            default: begin
                mode_d = ctm_pkg::MODE_RUN;
            end
        endcase
        if (lp_rst) begin
            mode_d = ctm_pkg::MODE_LOW_POWER_RESET_PIN;
        end else if (ext_rst) begin
            mode_d = ctm_pkg::MODE_RUN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q     <= ctm_pkg::MODE_RUN;
            stab_cnt_q <= '0;
        end else begin
            mode_q     <= mode_d;
            stab_cnt_q <= in_stab ? stab_cnt_q + 13'h0001 : 13'h0000;
        end
    end

    // Entry into stop or wait clears only the CPU I bit, never the external mask
    wire enter_low = (mode_q == ctm_pkg::MODE_RUN) & ~lp_rst & ~ext_rst
                   & (stop_req | wait_req);

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire apb_setup = psel & ~penable;
    wire apb_acc   = psel & penable & pready_q;
    wire hit_ctrl  = (paddr[11:2] == `CTM_IDX_CTRL);
    wire hit_count = (paddr[11:2] == `CTM_IDX_COUNT);
    wire unmapped  = ~(hit_ctrl | hit_count);
    wire wr_ctrl   = apb_acc & pwrite & hit_ctrl;
    wire ovf_clr   = wr_ctrl & pwdata[`CTM_BIT_OVF_CLR];
    wire per_clr   = wr_ctrl & pwdata[`CTM_BIT_PER_CLR];

    wire [7:0] ctrl_rd = {ovf_flag_q, per_flag_q, ovf_en_q, per_en_q,
                          1'b0, 1'b0, rate_q};
    wire [7:0] rd_byte = hit_ctrl  ? ctrl_rd   :
                         hit_count ? count_val : 8'h00;
    wire [31:0] prdata_d = (apb_setup & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= apb_setup;
            pslverr_q <= apb_setup & unmapped;
            prdata_q  <= prdata_d;
        end
    end

    // ------------------------------------------------------------------------
    // Flags and control
    // ------------------------------------------------------------------------
    // A set arriving with a clear wins; hardware reset beats both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag_q <= 1'b0;
            per_flag_q <= 1'b0;
            ovf_en_q   <= 1'b0;
            per_en_q   <= 1'b0;
            rate_q     <= `CTM_RATE_RST;
        end else if (soft_rst) begin
            ovf_flag_q <= 1'b0;
            per_flag_q <= 1'b0;
            ovf_en_q   <= 1'b0;
            per_en_q   <= 1'b0;
            rate_q     <= `CTM_RATE_RST;
        end else begin
            ovf_flag_q <= ovf_tick | (ovf_flag_q & ~ovf_clr);
            per_flag_q <= per_tick | (per_flag_q & ~per_clr);
            if (wr_ctrl) begin
                ovf_en_q <= pwdata[`CTM_BIT_OVF_EN];
                per_en_q <= pwdata[`CTM_BIT_PER_EN];
                rate_q   <= pwdata[`CTM_BIT_RATE_HI:`CTM_BIT_RATE_LO];
            end
        end
    end

    // ------------------------------------------------------------------------
    // CPU side outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q       <= 1'b0;
            cpu_reset_q <= 1'b1;
            cpu_halt_q  <= 1'b0;
            mask_clr_q  <= 1'b0;
            osc_run_q   <= 1'b1;
        end else begin
            irq_q       <= irq_raw & ~in_stop;
            cpu_reset_q <= soft_rst | lp_rst;
            cpu_halt_q  <= (mode_d == ctm_pkg::MODE_STOP) | (mode_d == ctm_pkg::MODE_WAIT);
            mask_clr_q  <= enter_low;
            osc_run_q   <= ~((mode_d == ctm_pkg::MODE_STOP) | (mode_d == ctm_pkg::MODE_LOW_POWER_RESET_PIN));
        end
    end

    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign prdata             = prdata_q;
    assign timer_irq          = irq_q;
    assign cpu_reset          = cpu_reset_q;
    assign cpu_halt           = cpu_halt_q;
    assign cpu_irq_mask_clear = mask_clr_q;
    assign osc_run            = osc_run_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_stop_entry;
        (mode_q == ctm_pkg::MODE_RUN) && stop_req && !lp_rst && !ext_rst;
    endsequence

    // The chain is cleared by the first edge spent in stop, so it reads zero one cycle later
    sequence s_stop_held;
        (mode_q == ctm_pkg::MODE_STOP) && cpu_irq_mask_clear ##1 (chain_q == '0);
    endsequence

    a_ovf_flag_set: assert property (ovf_tick && !soft_rst |=> ovf_flag_q)
        else $error("overflow flag not set after wrap");

    a_ovf_rate_1024: assert property (ovf_tick |->
                                      count_val == 8'hff && chain_q[1:0] == 2'h3)
        else $error("overflow outside counter wrap");

    a_ovf_clear: assert property (ovf_clr && !ovf_tick && !soft_rst |=> !ovf_flag_q)
        else $error("overflow flag not cleared");

    a_per_flag_keep: assert property (per_flag_q && !per_clr && !soft_rst |=> per_flag_q)
        else $error("periodic flag lost without clear");

    a_clear_bits_zero: assert property (apb_setup && !pwrite && hit_ctrl |=> prdata_q[3:2] == 2'h0)
        else $error("flag clear bits read nonzero");

    a_irq_level: assert property (irq_raw && !in_stop |=> timer_irq)
        else $error("enabled flag without interrupt");

    a_irq_drop: assert property (!irq_raw |=> !timer_irq)
        else $error("interrupt without enabled flag");

    a_rate_reset: assert property (soft_rst |=> rate_q == 2'h3)
        else $error("rate select not set by reset");

    a_stop_entry: assert property (s_stop_entry |=> s_stop_held)
        else $error("stop entry did not clear chain and mask");

    a_stop_exit: assert property (in_stop && ext_irq && !lp_rst && !ext_rst |=> !in_stop)
        else $error("pending interrupt did not end stop");

    a_wdog_bite: assert property (cop_bite |=> wdog_bite_q ##1 cpu_reset)
        else $error("watchdog timeout did not reset");

    a_wdog_clear: assert property (wdog_clear && !soft_rst && !in_stop |=> cop_q == '0
                                   && chain_q == $past(chain_q) + 15'h0001)
        else $error("watchdog clear touched more than its stage");

    a_stab_len: assert property (in_stab && mode_d == ctm_pkg::MODE_RUN && !ext_rst
                                 |-> stab_cnt_q == STAB_CYCLES - 13'h001)
        else $error("stabilisation period wrong length");

    a_apb_ready: assert property (apb_setup |=> pready ##1 !pready)
        else $error("apb ready not one cycle after setup");

endmodule : ctm_core_timer
`default_nettype wire

// ===== ctm_cpu_model.sv
// Purpose: Stand-in for the CPU core that faces the core timer
// Assumes: Commands from the bench are one-cycle pulses on pclk
// Notes:   Watchdog kicks repeat every 2048 cycles while kick_en is high
`default_nettype none
module ctm_cpu_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Commands from the bench
    input  wire logic cmd_stop,
    input  wire logic cmd_wait,
    input  wire logic kick_en,
    // From the timer
    input  wire logic cpu_halt,
    // To the timer
    output logic      stop_req,
    output logic      wait_req,
    output logic      wdog_clear
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [10:0] kick_cnt_q;

    // A halted CPU executes no stop or wait instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_req   <= 1'b0;
            wait_req   <= 1'b0;
            wdog_clear <= 1'b0;
            kick_cnt_q <= 11'h000;
        end else begin
            stop_req   <= cmd_stop && !cpu_halt;
            wait_req   <= cmd_wait && !cpu_halt;
            kick_cnt_q <= kick_en ? kick_cnt_q + 11'h001 : 11'h000;
            wdog_clear <= kick_en && (kick_cnt_q == 11'h000);
        end
    end
endmodule : ctm_cpu_model
`default_nettype wire

// ===== ctm_pkg.sv
// Purpose: Types shared by the core timer
// Assumes: ctm_cfg.svh holds the register and timing numbers; mode codes and widths are set here
// Notes:   Nothing is imported; users write ctm_pkg::name
`default_nettype none
package ctm_pkg;

    // ------------------------------------------------------------------------
    // Power mode of the device
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_RUN   = 3'b000,
        MODE_WAIT  = 3'b001,
        MODE_STOP  = 3'b010,
        MODE_LOW_POWER_RESET_PIN = 3'b011,
        MODE_STAB  = 3'b100
    } ctm_mode_e;

    typedef logic [1:0] ctm_rate_t;

endpackage : ctm_pkg
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench of the core timer over APB
// Assumes: ctm_cpu_model plays the CPU core; STAB_CYCLES shortened to 8
// Notes:   APB results are queued by the driver and compared by a monitor
`include "ctm_cfg.svh"
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int          STAB   = 8;
    localparam logic [11:0] A_CTRL = {`CTM_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_CNT  = {`CTM_IDX_COUNT, 2'b00};

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic        stop_req, wait_req, wdog_clear, timer_irq, cpu_reset, cpu_halt;
    logic        cpu_irq_mask_clear, osc_run, ext_irq_pin, lp_n, ext_n;
    logic        cmd_stop, cmd_wait, kick_en;
    logic [32:0] exp_q[$];
    logic [32:0] head;
    int          n_errors, compares, cyc, t0, n;

    ctm_core_timer #(.STAB_CYCLES(13'h008)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .stop_req(stop_req), .wait_req(wait_req),
        .wdog_clear(wdog_clear), .timer_irq(timer_irq), .cpu_reset(cpu_reset),
        .cpu_halt(cpu_halt), .cpu_irq_mask_clear(cpu_irq_mask_clear), .osc_run(osc_run),
        .ext_irq_pin(ext_irq_pin), .low_power_reset_pin_n(lp_n), .ext_reset_pin_n(ext_n));

    ctm_cpu_model cpu (
        .pclk(pclk), .presetn(presetn), .cmd_stop(cmd_stop), .cmd_wait(cmd_wait),
        .kick_en(kick_en), .cpu_halt(cpu_halt), .stop_req(stop_req),
        .wait_req(wait_req), .wdog_clear(wdog_clear));

    // ------------------------------------------------------------------------
    // Clock, cycle count and result monitor
    // ------------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) cyc <= cyc + 1;

    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            head = exp_q.pop_front();
            `CHK({pslverr, prdata}, head)
        end
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic results();
        if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [32:0] e);
        int k;
        @(posedge pclk);
        rnd = lfsr(rnd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {rnd[31:8], d};
        exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            $display("Error at %0t: apb answer timed out", $time);
            results();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00, {25'h0, e});
    endtask : rd

    function automatic logic pick(input int w);
        case (w)
            0: return timer_irq;
            1: return cpu_halt;
            2: return cpu_reset;
            default: return cpu_irq_mask_clear;
        endcase
    endfunction : pick

    task automatic wait_on(input int w, input logic lvl, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge pclk);
            cnt++;
        end while (pick(w) !== lvl && cnt < lim);
        if (pick(w) !== lvl) begin
            n_errors++;
            $display("Error at %0t: wait on signal %0d timed out", $time, w);
            results();
        end
    endtask : wait_on

    task automatic cmd(input logic stop);
        @(posedge pclk);
        cmd_stop <= stop;
        cmd_wait <= !stop;
        @(posedge pclk);
        cmd_stop <= 1'b0;
        cmd_wait <= 1'b0;
    endtask : cmd

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        n_errors = 0;
        compares = 0;
        cyc = 0;
        rnd = 32'h237b60ee;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_irq_pin, cmd_stop, cmd_wait} = 3'b000;
        {lp_n, ext_n, kick_en} = 3'b111;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_CTRL, 8'h03);
        apb(1'b0, 12'h100 | {4'h0, rnd[7:2], 2'b00}, 8'h00, {1'b1, 32'h0});
        wr(A_CNT, 8'hff);
        wr(A_CTRL, 8'h2b);
        wait_on(0, 1'b1, 1200, n);
        t0 = cyc;
        wr(A_CTRL, 8'heb);
        rd(A_CTRL, 8'h23);
        wait_on(0, 1'b1, 1100, n);
        `CHK(cyc - t0, 1024)
        wr(A_CTRL, 8'h03);
        repeat (2) @(posedge pclk);
        `CHK(timer_irq, 1'b0)
        for (int r = 0; r < 2; r++) begin
            // The request lags the flag clear by one cycle: let it fall first
            wr(A_CTRL, 8'h1c | 8'(r));
            wait_on(0, 1'b0, 8, n);
            wait_on(0, 1'b1, (4096 << r) + 64, n);
            t0 = cyc;
            wr(A_CTRL, 8'h1c | 8'(r));
            wait_on(0, 1'b0, 8, n);
            wait_on(0, 1'b1, (4096 << r) + 64, n);
            `CHK(cyc - t0, 4096 << r)
        end
        // Wait ends on the enabled overflow
        wr(A_CTRL, 8'h2f);
        cmd(1'b0);
        wait_on(1, 1'b1, 8, n);
        `CHK(osc_run, 1'b1)
        wait_on(1, 1'b0, 1100, n);
        `CHK(timer_irq, 1'b1)
        // Stop clears the chain and waits for the pin
        wr(A_CTRL, 8'h0f);
        cmd(1'b1);
        wait_on(3, 1'b1, 8, n);
        `CHK({cpu_halt, osc_run}, 2'b10)
        rd(A_CNT, 8'h00);
        repeat (20) @(posedge pclk);
        `CHK(cpu_halt, 1'b1)
        ext_irq_pin <= 1'b1;
        wait_on(1, 1'b0, 8, n);
        ext_irq_pin <= 1'b0;
        // One kick, then the fastest rate until the watchdog bites
        kick_en <= 1'b0;
        repeat (3) @(posedge pclk);
        kick_en <= 1'b1;
        @(posedge pclk);
        kick_en <= 1'b0;
        t0 = cyc;
        wr(A_CTRL, 8'h0c);
        wait_on(2, 1'b1, 33000, n);
        `CHK((cyc - t0 >= 7 * 4096) && (cyc - t0 <= 8 * 4096 + 8), 1'b1)
        rd(A_CTRL, 8'h03);
        kick_en <= 1'b1;
        lp_n <= 1'b0;
        wait_on(2, 1'b1, 8, n);
        @(posedge pclk);
        `CHK(osc_run, 1'b0)
        lp_n <= 1'b1;
        wait_on(2, 1'b0, STAB + 16, n);
        `CHK(n >= STAB, 1'b1)
        wr(A_CTRL, 8'h32);
        ext_n <= 1'b0;
        wait_on(2, 1'b1, 8, n);
        ext_n <= 1'b1;
        wait_on(2, 1'b0, 16, n);
        rd(A_CTRL, 8'h03);
        results();
    end
endmodule : testbench
`default_nettype wire
